// *** shared/ppm_regs.vh ***
// Register offsets, field limits, mode codes and reset values of the port block.
// Included by the port logic; holds definitions only.
`ifndef PPM_REGS_VH
`define PPM_REGS_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define PPM_PORT_A_VALUE        16'h1000
`define PPM_PORT_A_DIRECTION    16'h1001
`define PPM_LOW_ADDR_VALUE      16'h1002
`define PPM_LOW_ADDR_DIRECTION  16'h1003
`define PPM_HIGH_ADDR_VALUE     16'h1004
`define PPM_HIGH_ADDR_DIRECTION 16'h1005
`define PPM_DATA_BUS_VALUE      16'h1006
`define PPM_DATA_BUS_DIRECTION  16'h1007
`define PPM_SERIAL_VALUE        16'h1008
`define PPM_SERIAL_DIRECTION    16'h1009
`define PPM_INPUT_PORT_VALUE    16'h100A
`define PPM_PORT_G_VALUE        16'h1040
`define PPM_PORT_G_DIRECTION    16'h1041

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PPM_SERIAL_MASK         8'h3F
`define PPM_REG_RESET           8'h00
`define PPM_UNMAPPED_READ       8'h00
`define PPM_EXTERNAL_SELECT_STROBE_BIT            6
`define PPM_RW_BIT              7

// ------------------------------------------------------------
// Operating modes
// ------------------------------------------------------------
`define PPM_MODE_SINGLE         2'h0
`define PPM_MODE_EXPANDED       2'h1
`define PPM_MODE_BOOT           2'h2
`define PPM_MODE_TEST           2'h3

// ------------------------------------------------------------
// Memory map
// ------------------------------------------------------------
`define PPM_EXT_LOW             16'h4000
`define PPM_EXT_HIGH            16'h7FFF
`define PPM_BOOT_LOW            16'hBF00
`define PPM_BOOT_HIGH           16'hBFFF

`endif

// *** logic/ppm_port_block.v ***
// Parallel I/O ports with pin multiplexing and the mode-dependent external bus.
// Assumes one 40 MHz clock, pins outside that domain, and a CPU access port
// on the same clock that presents one access per cycle.
//
// Functional notes
// - Fifty-four I/O lines exist: ports A, B, C, E, F, G of eight bits and port D of six.
// - Outside alternate functions and the bus modes, each line of the bidirectional ports takes its direction from its bit of the port direction register.
// - The input-only port never drives and its value register reads the current pin levels.
// - Ports B, F, C and G6, G7 are general I/O only in single-chip and bootstrap modes.
// - In expanded and test modes B carries A8-A15, F carries A0-A7, C carries D0-D7, G6 the select and G7 read/write.
// - Port A serves captures, compares and the pulse accumulator input, and compare one may drive pins 3 to 7.
// - Port D pins 0 to 5 serve serial receive, transmit and the SPI lines in every mode when selected.
// - Single-chip mode makes no external bus addresses and all accesses stay internal.
// - Expanded mode sends accesses in 4000 to 7FFF hex to the external bus pins.
// - Bootstrap mode places the boot ROM at BF00 to BFFF hex and otherwise decodes as single-chip.
// - Test mode decodes as expanded mode but sends vector fetches to external memory.
// - Data registers sit at even offsets with direction at the next odd one, ports A, F, B, C, D at 1000 to 1009 hex.
// - Port D implements bits 0 to 5 only and bits 7 and 6 read as zero.
// - The active-low external select asserts only for an off-chip access in expanded and test modes.
// - Read/write shows the direction of each external data transfer and external devices honour it.
`timescale 1ns/1ps
`include "ppm_regs.vh"

module ppm_port_block (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Mode strap, two flops before use
    input  wire [1:0]  mode_sel,
    // Register port
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    // CPU memory access
    input  wire        cpu_valid,
    input  wire        cpu_write,
    input  wire        cpu_vector,
    input  wire [15:0] cpu_addr,
    input  wire [7:0]  cpu_wdata,
    output wire        cpu_external,
    output wire        cpu_boot_rom,
    output reg  [7:0]  cpu_ext_rdata,
    // Timer alternate functions on port A
    input  wire [7:0]  tim_a_sel,
    input  wire [7:0]  tim_a_out,
    input  wire [7:3]  compare_one_mask,
    input  wire [7:3]  compare_one_data,
    output wire [7:0]  tim_a_in,
    // Serial and SPI alternate functions on port D
    input  wire [5:0]  ser_d_sel,
    input  wire [5:0]  ser_d_oe,
    input  wire [5:0]  ser_d_out,
    output wire [5:0]  ser_d_in,
    // Port pins
    input  wire [7:0]  pa_in,
    output reg  [7:0]  pa_out,
    output reg  [7:0]  pa_oe,
    input  wire [7:0]  pb_in,
    output reg  [7:0]  pb_out,
    output reg  [7:0]  pb_oe,
    input  wire [7:0]  pc_in,
    output reg  [7:0]  pc_out,
    output reg  [7:0]  pc_oe,
    input  wire [5:0]  pd_in,
    output reg  [5:0]  pd_out,
    output reg  [5:0]  pd_oe,
    input  wire [7:0]  pe_in,
    input  wire [7:0]  pf_in,
    output reg  [7:0]  pf_out,
    output reg  [7:0]  pf_oe,
    input  wire [7:0]  pg_in,
    output reg  [7:0]  pg_out,
    output reg  [7:0]  pg_oe
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function bus_mode;
        input [1:0] m;
        begin
            bus_mode = (m == `PPM_MODE_EXPANDED) || (m == `PPM_MODE_TEST);
        end
    endfunction

    function pin_read;
        input dir;
        input val;
        input pin;
        begin
            pin_read = dir ? val : pin;
        end
    endfunction

    function [7:0] port_read;
        input [7:0] dir;
        input [7:0] val;
        input [7:0] pin;
        begin
            port_read = (dir & val) | (~dir & pin);
        end
    endfunction

    function in_window;
        input [15:0] addr;
        input [15:0] low;
        input [15:0] high;
        begin
            in_window = (addr >= low) && (addr <= high);
        end
    endfunction

    // ------------------------------------------------------------
    // Pin and strap synchronisers
    // ------------------------------------------------------------
    reg [53:0] pins_meta_q;
    reg [53:0] pins_q;
    reg [1:0]  mode_meta_q;
    reg [1:0]  mode_q;
    wire [53:0] pins_raw = {pg_in, pf_in, pe_in, pd_in, pc_in, pb_in, pa_in};

    // Pins carry no reset: they only follow the outside world
    always @(posedge clk_sys) begin
        pins_meta_q <= pins_raw;
        pins_q      <= pins_meta_q;
    end

    // Strap held at single-chip in reset so no bus cycle starts early
    always @(posedge clk_sys) begin
        mode_meta_q <= mode_sel;
        if (!rst_n) begin
            mode_q <= `PPM_MODE_SINGLE;
        end else begin
            mode_q <= mode_meta_q;
        end
    end

    wire [7:0] pa_s = pins_q[7:0];
    wire [7:0] pb_s = pins_q[15:8];
    wire [7:0] pc_s = pins_q[23:16];
    wire [5:0] pd_s = pins_q[29:24];
    wire [7:0] pe_s = pins_q[37:30];
    wire [7:0] pf_s = pins_q[45:38];
    wire [7:0] pg_s = pins_q[53:46];
    wire       bus_on = bus_mode(mode_q);
    wire       boot_on = (mode_q == `PPM_MODE_BOOT);
    wire       test_on = (mode_q == `PPM_MODE_TEST);

    // Alternate inputs see synchronised pin levels
    assign tim_a_in = pa_s;
    assign ser_d_in = pd_s;

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    reg [7:0] a_val_q;
    reg [7:0] a_dir_q;
    reg [7:0] f_val_q;
    reg [7:0] f_dir_q;
    reg [7:0] b_val_q;
    reg [7:0] b_dir_q;
    reg [7:0] c_val_q;
    reg [7:0] c_dir_q;
    reg [5:0] d_val_q;
    reg [5:0] d_dir_q;
    reg [7:0] g_val_q;
    reg [7:0] g_dir_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            a_val_q <= `PPM_REG_RESET;
            a_dir_q <= `PPM_REG_RESET;
            f_val_q <= `PPM_REG_RESET;
            f_dir_q <= `PPM_REG_RESET;
            b_val_q <= `PPM_REG_RESET;
            b_dir_q <= `PPM_REG_RESET;
            c_val_q <= `PPM_REG_RESET;
            c_dir_q <= `PPM_REG_RESET;
            d_val_q <= 6'h00;
            d_dir_q <= 6'h00;
        end else if (reg_write) begin
            case (reg_addr)
                `PPM_PORT_A_VALUE:        a_val_q <= reg_wdata;
                `PPM_PORT_A_DIRECTION:    a_dir_q <= reg_wdata;
                `PPM_LOW_ADDR_VALUE:      f_val_q <= reg_wdata;
                `PPM_LOW_ADDR_DIRECTION:  f_dir_q <= reg_wdata;
                `PPM_HIGH_ADDR_VALUE:     b_val_q <= reg_wdata;
                `PPM_HIGH_ADDR_DIRECTION: b_dir_q <= reg_wdata;
                `PPM_DATA_BUS_VALUE:      c_val_q <= reg_wdata;
                `PPM_DATA_BUS_DIRECTION:  c_dir_q <= reg_wdata;
                `PPM_SERIAL_VALUE:        d_val_q <= reg_wdata[5:0];
                `PPM_SERIAL_DIRECTION:    d_dir_q <= reg_wdata[5:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Port G registers; bits 7 and 6 yield to the bus in bus modes
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            g_val_q <= `PPM_REG_RESET;
            g_dir_q <= `PPM_REG_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                `PPM_PORT_G_VALUE:     g_val_q <= reg_wdata;
                `PPM_PORT_G_DIRECTION: g_dir_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register read, one cycle after the strobe
    // ------------------------------------------------------------
    reg [7:0] rd_d;

    always @* begin
        case (reg_addr)
            `PPM_PORT_A_VALUE:        rd_d = port_read(a_dir_q, a_val_q, pa_s);
            `PPM_PORT_A_DIRECTION:    rd_d = a_dir_q;
            `PPM_LOW_ADDR_VALUE:      rd_d = port_read(f_dir_q, f_val_q, pf_s);
            `PPM_LOW_ADDR_DIRECTION:  rd_d = f_dir_q;
            `PPM_HIGH_ADDR_VALUE:     rd_d = port_read(b_dir_q, b_val_q, pb_s);
            `PPM_HIGH_ADDR_DIRECTION: rd_d = b_dir_q;
            `PPM_DATA_BUS_VALUE:      rd_d = port_read(c_dir_q, c_val_q, pc_s);
            `PPM_DATA_BUS_DIRECTION:  rd_d = c_dir_q;
            `PPM_SERIAL_VALUE:        rd_d = port_read({2'h0, d_dir_q}, {2'h0, d_val_q}, {2'h0, pd_s});
            `PPM_SERIAL_DIRECTION:    rd_d = {2'h0, d_dir_q};
            `PPM_INPUT_PORT_VALUE:    rd_d = pe_s;
            `PPM_PORT_G_VALUE:        rd_d = port_read(g_dir_q, g_val_q, pg_s);
            `PPM_PORT_G_DIRECTION:    rd_d = g_dir_q;
            default:                  rd_d = `PPM_UNMAPPED_READ;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Memory map decode
    // ------------------------------------------------------------
    wire in_ext    = in_window(cpu_addr, `PPM_EXT_LOW, `PPM_EXT_HIGH);
    wire in_boot   = in_window(cpu_addr, `PPM_BOOT_LOW, `PPM_BOOT_HIGH);
    wire ext_read  = cpu_external && !cpu_write;
    wire ext_write = cpu_external && cpu_write;

    // Single-chip and boot never reach the pins
    assign cpu_external = cpu_valid && bus_on &&
                          (in_ext || (test_on && cpu_vector));
    assign cpu_boot_rom = cpu_valid && boot_on && in_boot;

    // Read data sampled from the synchronised data pins.
    // Pin flop plus two sync flops: hold an external read four cycles
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cpu_ext_rdata <= 8'h00;
        end else if (ext_read) begin
            cpu_ext_rdata <= pc_s;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, registered
    // ------------------------------------------------------------
    reg [7:0] a_out_d;
    reg [7:0] a_oe_d;
    reg [5:0] d_out_d;
    reg [5:0] d_oe_d;
    integer   i;

    always @* begin
        a_out_d = a_val_q;
        a_oe_d  = a_dir_q;
        for (i = 0; i < 8; i = i + 1) begin
            if (tim_a_sel[i]) begin
                a_out_d[i] = tim_a_out[i];
                a_oe_d[i]  = (i >= 3) && (i <= 6);
            end
        end
        // Compare one overrides the other sources on 3..7
        for (i = 3; i < 8; i = i + 1) begin
            if (compare_one_mask[i]) begin
                a_out_d[i] = compare_one_data[i];
                a_oe_d[i]  = 1'b1;
            end
        end
        // Serial and SPI take a pin from the port register when selected
        d_out_d = (ser_d_sel & ser_d_out) | (~ser_d_sel & d_val_q);
        d_oe_d  = (ser_d_sel & ser_d_oe) | (~ser_d_sel & d_dir_q);
    end

    // ------------------------------------------------------------
    // Bus-capable ports: address, data and strobes in bus modes
    // ------------------------------------------------------------
    reg [7:0] b_out_d;
    reg [7:0] b_oe_d;
    reg [7:0] f_out_d;
    reg [7:0] f_oe_d;
    reg [7:0] c_out_d;
    reg [7:0] c_oe_d;
    reg [7:0] g_out_d;
    reg [7:0] g_oe_d;

    always @* begin
        if (bus_on) begin
            // Address pins always driven, port registers ignored
            b_out_d = cpu_addr[15:8];
            b_oe_d  = 8'hFF;
            f_out_d = cpu_addr[7:0];
            f_oe_d  = 8'hFF;
            // Data pins driven only for an external write
            c_out_d = cpu_wdata;
            c_oe_d  = {8{ext_write}};
            // Select and read/write rest high between external cycles
            g_out_d = {!ext_write, !cpu_external, g_val_q[5:0]};
            g_oe_d  = {2'h3, g_dir_q[5:0]};
        end else begin
            b_out_d = b_val_q;
            b_oe_d  = b_dir_q;
            f_out_d = f_val_q;
            f_oe_d  = f_dir_q;
            c_out_d = c_val_q;
            c_oe_d  = c_dir_q;
            g_out_d = g_val_q;
            g_oe_d  = g_dir_q;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pa_out <= 8'h00;
            pa_oe  <= 8'h00;
            pb_out <= 8'h00;
            pb_oe  <= 8'h00;
            pc_out <= 8'h00;
            pc_oe  <= 8'h00;
            pd_out <= 6'h00;
            pd_oe  <= 6'h00;
            pf_out <= 8'h00;
            pf_oe  <= 8'h00;
            pg_out <= 8'h00;
            pg_oe  <= 8'h00;
        end else begin
            pa_out <= a_out_d;
            pa_oe  <= a_oe_d;
            pb_out <= b_out_d;
            pb_oe  <= b_oe_d;
            pc_out <= c_out_d;
            pc_oe  <= c_oe_d;
            pd_out <= d_out_d;
            pd_oe  <= d_oe_d;
            pf_out <= f_out_d;
            pf_oe  <= f_oe_d;
            pg_out <= g_out_d;
            pg_oe  <= g_oe_d;
        end
    end

endmodule

// *** dv/ppm_port_props.sv ***
// Checker for the port block: mode decode, bus strobes and pin timing.
// Sees only top-level ports; checks other than upper_zero_a apply once the strap has held for three edges.
`timescale 1ns/1ps
module ppm_port_props (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst_n,
    // Strap and register port
    input wire [1:0]  mode_sel,
    input wire [15:0] reg_addr,
    input wire        reg_read,
    input wire [7:0]  reg_rdata,
    // CPU access
    input wire        cpu_valid,
    input wire        cpu_write,
    input wire        cpu_vector,
    input wire [15:0] cpu_addr,
    input wire [7:0]  cpu_wdata,
    input wire        cpu_external,
    input wire        cpu_boot_rom,
    // Bus pins
    input wire [7:0]  pb_out,
    input wire [7:0]  pb_oe,
    input wire [7:0]  pf_out,
    input wire [7:0]  pc_out,
    input wire [7:0]  pc_oe,
    input wire [7:0]  pg_out,
    input wire [7:0]  pg_oe
);
    reg  [1:0] prev_q;
    reg  [1:0] cnt_q;
    // Strap passes two flops inside, so trust the mode only after three steady edges
    wire       steady  = (cnt_q == 2'h3) && (mode_sel == prev_q);
    wire       bus     = steady && mode_sel[0];
    wire       ext_win = (cpu_addr >= 16'h4000) && (cpu_addr <= 16'h7FFF);
    wire       boot_win = (cpu_addr >= 16'hBF00) && (cpu_addr <= 16'hBFFF);
    always @(posedge clk_sys) begin
        prev_q <= mode_sel;
        if (!rst_n || mode_sel != prev_q) begin
            cnt_q <= 2'h0;
        end else if (!steady) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    single_internal_a: assert property (steady && mode_sel == 2'h0 |-> !cpu_external)
        else $error("off-chip access in single-chip mode");
    window_external_a: assert property (bus && cpu_valid && ext_win |-> cpu_external)
        else $error("window access stayed internal");
    outside_internal_a: assert property (steady && mode_sel == 2'h1 && cpu_valid && !ext_win |-> !cpu_external)
        else $error("access outside window went off chip");
    boot_rom_a: assert property (steady && cpu_valid |-> cpu_boot_rom == (mode_sel == 2'h2 && boot_win))
        else $error("boot ROM select wrong");
    test_vector_a: assert property (steady && mode_sel == 2'h3 && cpu_valid && cpu_vector |-> cpu_external)
        else $error("vector fetch not external in test mode");
    select_strobe_a: assert property (bus |=> pg_oe[7:6] == 2'h3 && pg_out[6] == !$past(cpu_external))
        else $error("select strobe wrong");
    addr_rw_pins_a: assert property (bus && cpu_external |=> {pb_out, pf_out} == $past(cpu_addr)
        && pg_out[7] == !$past(cpu_write))
        else $error("address or read/write pins wrong");
    data_dir_a: assert property (bus && cpu_external |=> pc_oe == ($past(cpu_write) ? 8'hFF : 8'h00))
        else $error("data pin direction wrong");
    data_out_a: assert property (bus && cpu_external && cpu_write |=> pc_out == $past(cpu_wdata))
        else $error("data pins do not carry write data");
    bus_owns_a: assert property (bus |-> pb_oe == 8'hFF)
        else $error("address pins released in bus mode");
    upper_zero_a: assert property (reg_read && (reg_addr == 16'h1008 || reg_addr == 16'h1009)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("serial port upper bits not zero");
endmodule
bind ppm_port_block ppm_port_props i_props (.*);

// *** dv/ppm_ext_mem.sv ***
// External memory on the bus pins: 256 bytes on the low address byte.
// Assumes the bench resolves the data pins from both drivers.
`timescale 1ns/1ps
module ppm_ext_mem (
    // Clock
    input  wire       clk_sys,
    // Board-level bus pins
    input  wire [7:0] addr_lo,
    input  wire       sel_n,
    input  wire       rd_wr,
    input  wire [7:0] data_pin,
    output wire [7:0] data_drv
);
    reg [7:0] mem_q [0:255];
    reg [7:0] last_q = 8'h00;
    // Released lines show the inverse, so a stale byte never passes for data
    assign data_drv = (!sel_n && rd_wr) ? mem_q[addr_lo] : ~last_q;
    always @(posedge clk_sys) begin
        last_q <= data_pin;
        if (!sel_n && !rd_wr) begin
            mem_q[addr_lo] <= data_pin;
        end
    end
endmodule

// *** dv/ppm_port_block_bench.sv ***
// Self-checking bench for the port block: registers, pins and external bus.
// Assumes the memory model on ports F, C, G and pull-ups on port G.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin num_errors = num_errors + 1; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ppm_port_block_bench;
    reg         clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    reg         cpu_valid = 1'b0, cpu_write = 1'b0, cpu_vector = 1'b0, ext_s, boot_s;
    reg  [1:0]  mode_sel = 2'h0;
    reg  [15:0] reg_addr = 16'h0000, cpu_addr = 16'h0000, i;
    reg  [7:0]  reg_wdata = 8'h00, cpu_wdata = 8'h00, tim_a_sel = 8'h00, tim_a_out = 8'h00;
    reg  [7:0]  ext_a = 8'h05, ext_b = 8'hA5, pe_in = 8'h5A;
    reg  [4:0]  compare_one_mask = 5'h00, compare_one_data = 5'h00;
    reg  [5:0]  ser_d_sel = 6'h00, ser_d_oe = 6'h00, ser_d_out = 6'h00, ext_d = 6'h30;
    wire [7:0]  reg_rdata, cpu_ext_rdata, tim_a_in, mem_d, pa_in, pb_in, pc_in, pf_in, pg_in;
    wire [7:0]  pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, pf_out, pf_oe, pg_out, pg_oe;
    wire [5:0]  ser_d_in, pd_in, pd_out, pd_oe;
    wire        cpu_external, cpu_boot_rom;
    integer     num_errors = 0, tests_run = 0;
    assign pa_in = (pa_out & pa_oe) | (ext_a & ~pa_oe);
    assign pb_in = (pb_out & pb_oe) | (ext_b & ~pb_oe);
    assign pf_in = (pf_out & pf_oe) | (ext_b & ~pf_oe);
    assign pd_in = (pd_out & pd_oe) | (ext_d & ~pd_oe);
    assign pc_in = (pc_out & pc_oe) | (mem_d & ~pc_oe);
    // Port G pulled up, so a released strobe never selects the memory
    assign pg_in = pg_out | ~pg_oe;
    ppm_port_block i_ppm_port_block (.*);
    ppm_ext_mem i_ppm_ext_mem (.clk_sys(clk_sys), .addr_lo(pf_in), .sel_n(pg_in[6]), .rd_wr(pg_in[7]),
        .data_pin(pc_in), .data_drv(mem_d));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clk_sys);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] e);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clk_sys);
            reg_read <= 1'b0;
            #1 `CHK(reg_rdata, e)
        end
    endtask
    // Access held n edges; decode flags sampled in its first cycle
    task cpu(input [15:0] a, input w, input v, input [7:0] d, input integer n);
        begin
            @(posedge clk_sys);
            cpu_addr <= a;
            cpu_write <= w;
            cpu_vector <= v;
            cpu_wdata <= d;
            cpu_valid <= 1'b1;
            #1 ext_s = cpu_external;
            boot_s = cpu_boot_rom;
            repeat (n) @(posedge clk_sys);
            cpu_valid <= 1'b0;
            #1;
        end
    endtask
    task setm(input [1:0] m);
        begin
            @(posedge clk_sys);
            mode_sel <= m;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    initial begin
        #(25 * 6000);
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 16'h0; i < 16'h4; i = i + 16'h1) begin
            wr(16'h1001 + 16'h2 * i, 8'hFF);
            wr(16'h1000 + 16'h2 * i, {i[3:0], i[3:0]} + 8'h11);
        end
        @(posedge clk_sys);
        #1 `CHK({pa_out, pf_out, pb_out, pc_out}, 32'h11223344)
        `CHK({pa_oe, pf_oe, pc_oe}, 24'hFFFFFF)
        wr(16'h1005, 8'h0F);
        repeat (2) @(posedge clk_sys);
        rd(16'h1004, 8'hA3);
        `CHK(pb_oe, 8'h0F)
        wr(16'h1009, 8'hFF);
        wr(16'h1008, 8'hFF);
        rd(16'h1009, 8'h3F);
        rd(16'h1008, 8'h3F);
        `CHK(pd_oe, 6'h3F)
        wr(16'h100A, 8'hFF);
        rd(16'h100A, 8'h5A);
        rd(16'h2000, 8'h00);
        wr(16'h1040, 8'h40);
        wr(16'h1041, 8'hC0);
        @(posedge clk_sys);
        #1 `CHK({pg_oe, pg_out}, 16'hC040)
        cpu(16'h4000, 1'b0, 1'b0, 8'h00, 1);
        `CHK(ext_s, 1'b0)
        $display("single-chip ports done");
        @(posedge clk_sys);
        tim_a_sel <= 8'h7F;
        tim_a_out <= 8'h58;
        ser_d_sel <= 6'h3F;
        ser_d_oe <= 6'h0F;
        ser_d_out <= 6'h0A;
        repeat (4) @(posedge clk_sys);
        #1 `CHK({pa_oe[6:0], pa_out[6:3]}, {7'h78, 4'hB})
        `CHK(tim_a_in[2:0], 3'h5)
        `CHK({pd_oe, pd_out[3:0]}, {6'h0F, 4'hA})
        `CHK(ser_d_in[5:4], 2'h3)
        @(posedge clk_sys);
        compare_one_mask <= 5'h11;
        compare_one_data <= 5'h10;
        repeat (3) @(posedge clk_sys);
        #1 `CHK({pa_oe[7], pa_out[7], pa_out[3]}, 3'h6)
        $display("alternate functions done");
        setm(2'h1);
        wr(16'h1005, 8'h00);
        @(posedge clk_sys);
        #1 `CHK(pb_oe, 8'hFF)
        cpu(16'h4005, 1'b1, 1'b0, 8'h55, 1);
        `CHK(ext_s, 1'b1)
        cpu(16'h4005, 1'b0, 1'b0, 8'h00, 5);
        `CHK(cpu_ext_rdata, 8'h55)
        cpu(16'h1000, 1'b0, 1'b0, 8'h00, 1);
        `CHK(ext_s, 1'b0)
        $display("expanded mode done");
        setm(2'h2);
        cpu(16'hBF80, 1'b0, 1'b0, 8'h00, 1);
        `CHK({ext_s, boot_s}, 2'h1)
        cpu(16'h4000, 1'b0, 1'b0, 8'h00, 1);
        `CHK({ext_s, boot_s}, 2'h0)
        $display("boot mode done");
        setm(2'h3);
        cpu(16'h0123, 1'b0, 1'b1, 8'h00, 1);
        `CHK(ext_s, 1'b1)
        cpu(16'h4010, 1'b1, 1'b0, 8'hAA, 1);
        cpu(16'h4010, 1'b0, 1'b0, 8'h00, 5);
        `CHK({ext_s, cpu_ext_rdata}, 9'h1AA)
        $display("test mode done");
        tally_and_finish;
    end
endmodule
